// >>> design/camc_cfg.svh
// Operation
// - Only first-empty device acts on next-free instructions
// - Move comparand to next free, mark valid
// - Last device full output flags whole string
// - Translation reverses bit order within each byte
// - Two control bits persistently select translation
// - Reset defaults to no translation
// - Page address write needs eligible chain position
// - Force-full acts only at chain position, drives full
// - Control reset clears full, keeps page address
// - Zero written to control register resets device
// - Select all ones: writes everywhere, reads only matcher
// - Init cycles are command cycles, write or read
// - Typical control value: increment address, no masking
// - Typical segment value: write 1-3, read 0
// - Last force-full drives last device full output
// - Address flag: next command write loads pointer
// - Pointer steps after move at pointer or address-flag load, per control
// - Force-full decoded from fixed command word
// - Override steers only next command cycle to register
`ifndef CAMC_CFG_SVH
`define CAMC_CFG_SVH

// APB word offsets.
`define CAMC_OFS_CMD      8'h00
`define CAMC_OFS_DATA     8'h04
`define CAMC_OFS_CHAIN    8'h08

// Command word fields.
`define CAMC_OP_SPS       3'h0
`define CAMC_OP_TCO       3'h2
`define CAMC_OP_MOV       3'h3
`define CAMC_OP_SFF       3'h7
`define CAMC_CMD_SFF      16'h0700
`define CAMC_ALL_ONES     16'hFFFF
`define CAMC_ZERO16       16'h0000

// Register selector codes for the one-shot override and move fields.
`define CAMC_SEL_CT       3'h0
`define CAMC_SEL_SC       3'h1
`define CAMC_SEL_PA       3'h2
`define CAMC_SEL_DS       3'h3
`define CAMC_SEL_AR       3'h4
`define CAMC_SEL_NONE     3'h7
`define CAMC_LOC_CR       3'h0
`define CAMC_LOC_MEM_AR   3'h4
`define CAMC_LOC_NF       3'h6

// Control register fields.
`define CAMC_CT_XL_HI     10
`define CAMC_CT_XL_LO     9
`define CAMC_CT_XL_ON     2'h2
`define CAMC_CT_XL_OFF    2'h1
`define CAMC_CT_AR_HI     3
`define CAMC_CT_AR_LO     2
`define CAMC_CT_AR_INC    2'h0
`define CAMC_CT_AR_DEC    2'h1

// Reset values.
`define CAMC_CT_RST       16'h0000
`define CAMC_SC_RST       16'h0000
`define CAMC_PA_RST       16'h0000
`define CAMC_DS_RST       16'hFFFF
`define CAMC_VAL_EMPTY    2'h1
`define CAMC_VAL_VALID    2'h0

`endif

// >>> design/camc_pkg.sv
`default_nettype none
`include "camc_cfg.svh"
package camc_pkg;
	typedef enum logic [2:0] {
		CAMC_TGT_CT   = `CAMC_SEL_CT,
		CAMC_TGT_SC   = `CAMC_SEL_SC,
		CAMC_TGT_PA   = `CAMC_SEL_PA,
		CAMC_TGT_DS   = `CAMC_SEL_DS,
		CAMC_TGT_AR   = `CAMC_SEL_AR,
		CAMC_TGT_NONE = `CAMC_SEL_NONE
	} camc_tgt_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic        write;
		logic [31:0] wdata;
	} camc_apb_req_t;
endpackage
`default_nettype wire

// >>> design/camc_xlate.sv
`timescale 1ns/100ps
`default_nettype none
module camc_xlate (
	// Data.
	input  wire logic [15:0] i_data,
	input  wire logic        i_on,
	output logic      [15:0] o_data
);
	logic [15:0] swapped;

	genvar n;
	generate
		for (n = 0; n < 8; n++) begin : g_bit
			assign swapped[7 - n]  = i_data[n];
			assign swapped[15 - n] = i_data[n + 8];
		end
	endgenerate

	assign o_data = i_on ? swapped : i_data;
endmodule
`default_nettype wire

// >>> design/camc_top.sv
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "camc_cfg.svh"
module camc_top
	import camc_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RST_N,
	// APB slave.
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Cascade chain.
	input  wire logic        I_FULL_FLAG_IN_N,
	output logic             O_FULL_FLAG_OUT_N,
	output logic             O_MATCH_ANY_OUT_N
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || DEPTH > 16384 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("camc_top: DEPTH must be a power of two from 2 to 16384");
	end

	camc_apb_req_t req;
	logic          act;
	logic          pre;
	logic          fi_meta;
	logic          fi_sync;
	logic [15:0]   control;
	logic [15:0]   seg_ctrl;
	logic [15:0]   page_address;
	logic [15:0]   device_select;
	logic [15:0]   address_pointer;
	logic [63:0]   comparand_reg;
	logic [2:0]    src_sel;
	logic [1:0]    dst_seg;
	logic [1:0]    src_seg;
	logic          xlate_on;
	logic          force_full;
	logic          addr_pend;
	logic          mov_pend;
	camc_tgt_t     ovr;
	logic [63:0]   mem_data [DEPTH];
	logic [1:0]    mem_val  [DEPTH];
	logic          upstream_full;
	logic          no_empty;
	logic          full_here;
	logic          eligible;
	logic [AW-1:0] nf_idx;
	logic          match_any;
	logic [AW-1:0] ar_idx;
	logic          wr_sel;
	logic          rd_ok;
	logic          cmd_wr;
	logic          cmd_rd;
	logic          dat_wr;
	logic          dat_rd;
	logic          sw_rst;
	logic          any_rst;
	logic [15:0]   wd16;
	logic [15:0]   wd_xl;
	logic [2:0]    op;
	logic          plain_cmd;
	logic          do_sff;
	logic          mov_nf;
	logic          mov_ar_now;
	logic          mem_wr;
	logic [AW-1:0] mem_idx;
	logic          step_ar;
	logic [15:0]   next_ar;
	logic          next_pready;
	logic [31:0]   next_prdata;
	logic          next_pslverr;

	assign req       = '{addr: I_PADDR, write: I_PWRITE, wdata: I_PWDATA};
	assign wd16      = req.wdata[15:0];
	assign op        = wd16[10:8];
	assign pre       = I_PSEL & I_PENABLE & ~O_PREADY;
	assign act       = I_PSEL & I_PENABLE & O_PREADY;

	// The chain flag comes from another device, so it is synchronised first.
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			fi_meta <= 1'b1;
			fi_sync <= 1'b1;
		end else begin
			fi_meta <= I_FULL_FLAG_IN_N;
			fi_sync <= fi_meta;
		end
	end

	// Lowest empty entry and match search over the whole array.
	always_comb begin
		no_empty  = 1'b1;
		nf_idx    = '0;
		match_any = 1'b0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (mem_val[i] == `CAMC_VAL_EMPTY) begin
				no_empty = 1'b0;
				nf_idx   = AW'(i);
			end
			if (mem_val[i] == `CAMC_VAL_VALID && mem_data[i] == comparand_reg) begin
				match_any = 1'b1;
			end
		end
	end

	assign upstream_full = ~fi_sync;
	assign full_here     = upstream_full & (no_empty | force_full);
	assign eligible      = upstream_full & ~full_here;
	assign ar_idx        = address_pointer[AW-1:0];

	// Writes go to every device when selection is open; reads need a match then.
	assign wr_sel = (device_select == `CAMC_ALL_ONES) || (device_select == page_address);
	assign rd_ok  = (device_select == `CAMC_ALL_ONES) ? match_any
	                                                  : (device_select == page_address);

	assign cmd_wr = act & req.write & (req.addr == `CAMC_OFS_CMD) & wr_sel;
	assign cmd_rd = act & ~req.write & (req.addr == `CAMC_OFS_CMD) & rd_ok;
	assign dat_wr = act & req.write & (req.addr == `CAMC_OFS_DATA) & wr_sel;
	assign dat_rd = act & ~req.write & (req.addr == `CAMC_OFS_DATA) & rd_ok;

	assign plain_cmd = cmd_wr & (ovr == CAMC_TGT_NONE) & ~addr_pend & (wd16[15:12] == 4'h0);
	assign sw_rst    = cmd_wr & (ovr == CAMC_TGT_CT) & (wd16 == `CAMC_ZERO16);
	assign any_rst   = ~I_RST_N | sw_rst;
	assign do_sff    = cmd_wr & (ovr == CAMC_TGT_NONE) & ~addr_pend
	                   & (wd16 == `CAMC_CMD_SFF) & eligible;
	assign mov_nf    = plain_cmd & (op == `CAMC_OP_MOV) & (wd16[5:3] == `CAMC_LOC_NF)
	                   & (wd16[2:0] == `CAMC_LOC_CR) & eligible;
	assign mov_ar_now = plain_cmd & (op == `CAMC_OP_MOV) & ~wd16[11]
	                    & (wd16[5:3] == `CAMC_LOC_MEM_AR) & (wd16[2:0] == `CAMC_LOC_CR);
	assign mem_wr    = mov_nf | mov_ar_now | (cmd_wr & addr_pend & mov_pend);
	assign mem_idx   = mov_nf ? nf_idx : ((cmd_wr & addr_pend) ? wd16[AW-1:0] : ar_idx);
	assign step_ar   = mov_ar_now | (cmd_wr & addr_pend);

	camc_xlate u_xlate (
		.i_data (wd16),
		.i_on   (xlate_on),
		.o_data (wd_xl)
	);

	// The pointer steps from the value just used by a memory access.
	always_comb begin
		next_ar = (cmd_wr & addr_pend) ? wd16 : address_pointer;
		if (step_ar) begin
			if (control[`CAMC_CT_AR_HI:`CAMC_CT_AR_LO] == `CAMC_CT_AR_INC) begin
				next_ar = next_ar + 16'h0001;
			end else if (control[`CAMC_CT_AR_HI:`CAMC_CT_AR_LO] == `CAMC_CT_AR_DEC) begin
				next_ar = next_ar - 16'h0001;
			end
		end
		if (cmd_wr && ovr == CAMC_TGT_AR) begin
			next_ar = wd16;
		end
	end

	// Control, segment and select registers reached through the override.
	always_ff @(posedge I_REF_CLK) begin
		if (any_rst) begin
			control       <= `CAMC_CT_RST;
			seg_ctrl      <= `CAMC_SC_RST;
			device_select <= `CAMC_DS_RST;
		end else if (cmd_wr) begin
			if (ovr == CAMC_TGT_CT) begin
				control <= wd16;
			end else if (ovr == CAMC_TGT_SC) begin
				seg_ctrl <= wd16;
			end else if (ovr == CAMC_TGT_DS) begin
				device_select <= wd16;
			end
		end
	end

	// Page address survives a software reset; only the pin clears it.
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			page_address <= `CAMC_PA_RST;
		end else if (cmd_wr && ovr == CAMC_TGT_PA && eligible) begin
			page_address <= wd16;
		end
	end

	// One-shot override and address-field sequencing.
	always_ff @(posedge I_REF_CLK) begin
		if (any_rst) begin
			ovr       <= CAMC_TGT_NONE;
			addr_pend <= 1'b0;
			mov_pend  <= 1'b0;
			src_sel   <= `CAMC_LOC_CR;
		end else if (cmd_wr) begin
			if (ovr != CAMC_TGT_NONE || addr_pend) begin
				ovr       <= CAMC_TGT_NONE;
				addr_pend <= 1'b0;
				mov_pend  <= 1'b0;
			end else if (plain_cmd && op == `CAMC_OP_TCO && wd16[7:6] == 2'h0 && wd16[2:0] == 3'h0) begin
				ovr <= camc_tgt_t'(wd16[5:3]);
			end else if (plain_cmd && op == `CAMC_OP_SPS) begin
				src_sel   <= wd16[2:0];
				addr_pend <= wd16[11];
			end else if (plain_cmd && op == `CAMC_OP_MOV && wd16[11]) begin
				addr_pend <= 1'b1;
				mov_pend  <= (wd16[5:3] == `CAMC_LOC_MEM_AR) && (wd16[2:0] == `CAMC_LOC_CR);
			end
		end else if (cmd_rd && ovr != CAMC_TGT_NONE) begin
			ovr <= CAMC_TGT_NONE;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (any_rst) begin
			address_pointer <= 16'h0000;
		end else begin
			address_pointer <= next_ar;
		end
	end

	// Forced full is a chain-position marker, not real occupancy.
	always_ff @(posedge I_REF_CLK) begin
		if (any_rst) begin
			force_full <= 1'b0;
		end else if (do_sff) begin
			force_full <= 1'b1;
		end
	end

	// Translation is sticky until the opposite code is written.
	always_ff @(posedge I_REF_CLK) begin
		if (any_rst) begin
			xlate_on <= 1'b0;
		end else if (cmd_wr && ovr == CAMC_TGT_CT) begin
			if (wd16[`CAMC_CT_XL_HI:`CAMC_CT_XL_LO] == `CAMC_CT_XL_ON) begin
				xlate_on <= 1'b1;
			end else if (wd16[`CAMC_CT_XL_HI:`CAMC_CT_XL_LO] == `CAMC_CT_XL_OFF) begin
				xlate_on <= 1'b0;
			end
		end
	end

	// Data cycles walk the comparand in 16-bit segments.
	always_ff @(posedge I_REF_CLK) begin
		if (any_rst) begin
			comparand_reg <= 64'h0000_0000_0000_0000;
			dst_seg       <= 2'h0;
		end else if (dat_wr) begin
			comparand_reg[dst_seg*16 +: 16] <= wd_xl;
			dst_seg                         <= dst_seg + 2'h1;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (any_rst) begin
			src_seg <= 2'h0;
		end else if (dat_rd) begin
			src_seg <= src_seg + 2'h1;
		end
	end

	// Entry storage; a move into memory always marks the entry valid.
	generate
		for (genvar e = 0; e < DEPTH; e++) begin : g_ent
			always_ff @(posedge I_REF_CLK) begin
				if (any_rst) begin
					mem_val[e]  <= `CAMC_VAL_EMPTY;
					mem_data[e] <= 64'h0000_0000_0000_0000;
				end else if (mem_wr && mem_idx == AW'(e)) begin
					mem_val[e]  <= `CAMC_VAL_VALID;
					mem_data[e] <= comparand_reg;
				end
			end
		end
	endgenerate

	// Read data is prepared in the first access cycle, so one wait state.
	always_comb begin
		next_pready  = pre;
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (pre && !req.write) begin
			if (req.addr == `CAMC_OFS_CMD) begin
				if (ovr == CAMC_TGT_CT) begin
					next_prdata[15:0] = control;
				end else if (ovr == CAMC_TGT_SC) begin
					next_prdata[15:0] = seg_ctrl;
				end else if (ovr == CAMC_TGT_PA) begin
					next_prdata[15:0] = page_address;
				end else if (ovr == CAMC_TGT_DS) begin
					next_prdata[15:0] = device_select;
				end else if (ovr == CAMC_TGT_AR) begin
					next_prdata[15:0] = address_pointer;
				end else begin
					next_prdata[15:0] = {match_any, full_here, 14'(nf_idx)};
				end
				next_pslverr = ~rd_ok;
			end else if (req.addr == `CAMC_OFS_DATA) begin
				if (src_sel == `CAMC_LOC_MEM_AR) begin
					next_prdata[15:0] = mem_data[ar_idx][src_seg*16 +: 16];
				end else begin
					next_prdata[15:0] = comparand_reg[src_seg*16 +: 16];
				end
				next_pslverr = ~rd_ok;
			end else if (req.addr == `CAMC_OFS_CHAIN) begin
				next_prdata = {page_address, 12'h000, xlate_on, force_full, eligible, full_here};
			end else begin
				next_pslverr = 1'b1;
			end
		end else if (pre) begin
			next_pslverr = (req.addr != `CAMC_OFS_CMD) && (req.addr != `CAMC_OFS_DATA);
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= next_pready;
			O_PRDATA  <= next_prdata;
			O_PSLVERR <= next_pslverr;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			O_FULL_FLAG_OUT_N <= 1'b1;
			O_MATCH_ANY_OUT_N <= 1'b1;
		end else begin
			O_FULL_FLAG_OUT_N <= ~full_here;
			O_MATCH_ANY_OUT_N <= ~match_any;
		end
	end
endmodule
`default_nettype wire

// >>> bench/camc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module camc_checker #(
	parameter int DEPTH = 16
) (
	// Clock, reset and APB.
	input wire logic        I_REF_CLK,
	input wire logic        I_RST_N,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [7:0]  I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	// Chain.
	input wire logic        I_FULL_FLAG_IN_N,
	input wire logic        O_FULL_FLAG_OUT_N,
	input wire logic        O_MATCH_ANY_OUT_N
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);
	logic       ovr;
	logic [2:0] tgt;
	logic [2:0] fi_cnt;
	logic       fi_last;
	wire        acc       = I_PSEL && I_PENABLE && O_PREADY && I_PADDR == 8'h00;
	wire        acc_w     = acc && I_PWRITE;
	wire        sff_go    = acc_w && !ovr && I_PWDATA[15:0] == 16'h0700;
	wire        swr       = acc_w && ovr && tgt == 3'h0 && I_PWDATA[15:0] == 16'h0000;
	wire        fi_stable = fi_cnt >= 3'h4;
	// Mirrors the one-shot steering so that command words are decoded as the device sees them.
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			ovr <= 1'b0;
			tgt <= 3'h7;
		end else if (acc && (!I_PWRITE && !O_PSLVERR || I_PWRITE && ovr)) begin
			ovr <= 1'b0;
		end else if (acc_w) begin
			ovr <= I_PWDATA[15:6] == 10'h008 && I_PWDATA[2:0] == 3'h0;
			tgt <= I_PWDATA[5:3];
		end
	end
	// Full-in crosses a synchronizer, so only a level held for some cycles is trusted.
	always_ff @(posedge I_REF_CLK) begin
		fi_last <= I_FULL_FLAG_IN_N;
		if (!I_RST_N || I_FULL_FLAG_IN_N != fi_last) begin
			fi_cnt <= 3'h0;
		end else if (!fi_stable) begin
			fi_cnt <= fi_cnt + 3'h1;
		end
	end
	sequence s_setup; I_PSEL && !I_PENABLE; endsequence
	sequence s_wait; I_PSEL && I_PENABLE && !O_PREADY; endsequence
	a_ready_one_wait: assert property (s_setup ##1 s_wait |=> O_PREADY)
		else $error("ready not after one wait");
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	a_ready_in_access: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
		else $error("ready outside access phase");
	a_reset_flags: assert property ($rose(I_RST_N) |-> O_FULL_FLAG_OUT_N && O_MATCH_ANY_OUT_N)
		else $error("flags active out of reset");
	a_sff_forces: assert property (sff_go && !I_FULL_FLAG_IN_N && fi_stable && O_FULL_FLAG_OUT_N
		|-> ##[1:3] !O_FULL_FLAG_OUT_N) else $error("force full did not act");
	a_sff_ignored: assert property (sff_go && I_FULL_FLAG_IN_N && fi_stable && O_FULL_FLAG_OUT_N
		|=> O_FULL_FLAG_OUT_N [*3]) else $error("force full acted off position");
	a_swreset_full: assert property (swr |-> ##[1:3] O_FULL_FLAG_OUT_N)
		else $error("software reset kept full");
	a_unmapped_err: assert property (O_PREADY && !(I_PADDR inside {8'h00, 8'h04, 8'h08}) |-> O_PSLVERR)
		else $error("unmapped access not refused");
endmodule
bind camc_top camc_checker #(.DEPTH(DEPTH)) u_chk (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
	.I_FULL_FLAG_IN_N(I_FULL_FLAG_IN_N), .O_FULL_FLAG_OUT_N(O_FULL_FLAG_OUT_N),
	.O_MATCH_ANY_OUT_N(O_MATCH_ANY_OUT_N));
`default_nettype wire

// >>> bench/camc_up_model.sv
`timescale 1ns/100ps
`default_nettype none
module camc_up_model (
	// Link.
	input  wire logic i_clk,
	input  wire logic i_up_full,
	output logic      o_full_flag_in_n
);
	// Only a full upstream string hands the next-free role down to this device.
	always @(posedge i_clk) begin
		o_full_flag_in_n <= !i_up_full;
	end
endmodule
`default_nettype wire

// >>> bench/camc_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module camc_top_test;
	localparam int DEPTH = 4;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        fi_n, ff_n, ma_n, up_full, rd_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_data;
	int          n_errors;
	int          samples_checked;
	camc_top #(.DEPTH(DEPTH)) DUT (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_FULL_FLAG_IN_N(fi_n),
		.O_FULL_FLAG_OUT_N(ff_n), .O_MATCH_ANY_OUT_N(ma_n));
	camc_up_model u_up (.i_clk(clk), .i_up_full(up_full), .o_full_flag_in_n(fi_n));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// Ready is sampled at the rising edge, so the request stands until the edge that completes it.
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		chk(pready, 32'h1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cw(input logic [15:0] d);
		apb(1'b1, 8'h00, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 16'h0000);
	endtask
	task automatic set(input logic [2:0] sel, input logic [15:0] v);
		cw(16'h0200 | {10'h000, sel, 3'h0});
		cw(v);
	endtask
	function automatic logic [15:0] rev(input logic [15:0] d);
		logic [15:0] q;
		for (int n = 0; n < 16; n++) begin
			if (n < 8) q[7 - n] = d[n];
			else q[23 - n] = d[n];
		end
		return q;
	endfunction
	task automatic t_reset();
		rd(8'h08);
		chk(rd_data, 32'h00000002);
		chk(ff_n, 32'h1);
		rd(8'h00);
		chk(rd_err, 32'h1);
		rd(8'h0C);
		chk(rd_err, 32'h1);
	endtask
	task automatic t_page();
		set(3'h2, 16'h0005);
		cw(16'h0700);
		idle(3);
		chk(ff_n, 32'h0);
		rd(8'h08);
		chk(rd_data, 32'h00050005);
		set(3'h2, 16'h0009);
		rd(8'h08);
		chk(rd_data, 32'h00050005);
		set(3'h0, 16'h0000);
		rd(8'h08);
		chk(rd_data, 32'h00050002);
		chk(ff_n, 32'h1);
	endtask
	task automatic t_inel();
		set(3'h3, 16'h0005);
		up_full <= 1'b0;
		idle(6);
		cw(16'h0700);
		cw(16'h0330);
		idle(3);
		chk(ff_n, 32'h1);
		rd(8'h00);
		chk(rd_data, 32'h00000000);
		rd(8'h08);
		chk(rd_data, 32'h00050000);
		up_full <= 1'b1;
		idle(6);
	endtask
	task automatic t_xlate();
		set(3'h0, 16'h0400);
		rd(8'h08);
		chk(rd_data, 32'h0005000A);
		apb(1'b1, 8'h04, 16'h1234);
		rd(8'h04);
		chk(rd_data, {16'h0000, rev(16'h1234)});
		set(3'h0, 16'h0200);
		rd(8'h08);
		chk(rd_data, 32'h00050002);
		apb(1'b1, 8'h04, 16'h1234);
		rd(8'h04);
		chk(rd_data, 32'h00001234);
	endtask
	task automatic t_ar();
		cw(16'h0B20);
		cw(16'h0002);
		cw(16'h0220);
		rd(8'h00);
		chk(rd_data, 32'h00000003);
		set(3'h0, 16'h0004);
		cw(16'h0320);
		cw(16'h0220);
		rd(8'h00);
		chk(rd_data, 32'h00000002);
		set(3'h0, 16'h0000);
	endtask
	task automatic t_nf();
		set(3'h3, 16'h0005);
		cw(16'h0330);
		rd(8'h00);
		chk(rd_data, 32'h00008001);
		chk(ma_n, 32'h0);
		repeat (DEPTH - 1) cw(16'h0330);
		idle(3);
		chk(ff_n, 32'h0);
		rd(8'h00);
		chk(rd_data[15:14], 32'h3);
		set(3'h3, 16'hFFFF);
		rd(8'h00);
		chk(rd_err, 32'h0);
		set(3'h0, 16'h8040);
		cw(16'h0200);
		rd(8'h00);
		chk(rd_data, 32'h00008040);
		set(3'h1, 16'h3808);
		cw(16'h0208);
		rd(8'h00);
		chk(rd_data, 32'h00003808);
	endtask
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		up_full = 1'b1;
		n_errors = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		idle(4);
		t_reset();
		t_page();
		t_inel();
		t_xlate();
		t_ar();
		t_nf();
		give_verdict();
	end
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
